// [src/ascq_defines.svh]
// register offsets, field positions, reset values and timing counts of the sequencer control block
// assumes inclusion by bare name from every file that needs them
`ifndef ASCQ_DEFINES_SVH
`define ASCQ_DEFINES_SVH
// ==========================================================
// register offsets (byte addresses)
`define ASCQ_OFF_ACTIVE 12'h000
`define ASCQ_OFF_RAW 12'h004
`define ASCQ_OFF_MASK 12'h008
`define ASCQ_OFF_ISC 12'h00C
`define ASCQ_OFF_OVF 12'h010
`define ASCQ_OFF_EMUX 12'h014
`define ASCQ_OFF_UNF 12'h018
`define ASCQ_OFF_PRI 12'h020
`define ASCQ_OFF_INIT 12'h028
`define ASCQ_OFF_AVG 12'h030
// per-sequencer blocks start at 0x040, one every 0x020
`define ASCQ_SEQ_BLK_FIRST 7'h02
`define ASCQ_SEQ_BLK_LAST 7'h05
`define ASCQ_SUB_INSEL 2'h0
`define ASCQ_SUB_CTL 2'h1
`define ASCQ_SUB_FIFO 2'h2
`define ASCQ_SUB_STAT 2'h3
// ==========================================================
// reset values and fields
`define ASCQ_RST_PRI 16'h3210
`define ASCQ_PRI_MASK 16'h3333
`define ASCQ_RST_CTL3 32'h00000002
`define ASCQ_CTL_DIFF 0
`define ASCQ_CTL_END 1
`define ASCQ_CTL_IRQ 2
`define ASCQ_CTL_TEMP 3
`define ASCQ_STAT_TAIL 0
`define ASCQ_STAT_HEAD 4
`define ASCQ_STAT_EMPTY 8
`define ASCQ_STAT_FULL 12
`define ASCQ_TRIG_SW 4'h0
`define ASCQ_TRIG_ALWAYS 4'hF
`define ASCQ_AVG_MAX_LOG 3'h6
// ==========================================================
// timing
`define ASCQ_PCLK_KHZ 50000
`define ASCQ_CONV_MAX_KHZ 18000
`define ASCQ_CONV_DIV ((`ASCQ_PCLK_KHZ + `ASCQ_CONV_MAX_KHZ - 1) / `ASCQ_CONV_MAX_KHZ)
`endif

// [src/ascq_pkg.sv]
// types shared by the sequencer control block
// assumes nothing beyond a SystemVerilog compiler
package ascq_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT, SEQ_STORE} ascq_state_t;

	typedef struct packed {
		logic [3:0] active;
		logic [3:0] raw;
		logic [3:0] mask;
		logic [3:0] ovf;
		logic [3:0] unf;
		logic [15:0] emux;
		logic [15:0] pri;
		logic [2:0] avg;
		logic [3:0][31:0] insel;
		logic [3:0][31:0] ctl;
		logic [3:0] pend;
		ascq_state_t state;
		logic [1:0] seq;
		logic [2:0] step;
		logic [15:0] acc;
		logic [6:0] avg_cnt;
		logic conv_start;
		logic [1:0] pos_sel;
		logic [1:0] neg_sel;
		logic diff;
		logic temp;
		logic [9:0] result;
		logic apb_wait;
		logic fifo_rd;
		logic err;
		logic [31:0] rdata;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] trig_lvl;
	} ascq_st_t;
endpackage

// [src/ascq_clkdiv.sv]
// converter clock enable: one-cycle pulse every DIV bus clocks
// assumes a free-running pclk
`timescale 1ns/1ps
module ascq_clkdiv #(
	parameter int DIV = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} ascq_div_t;

	ascq_div_t st_ff;
	ascq_div_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = (st_ff.cnt == 8'(DIV - 1));
		nxt_st.cnt = nxt_st.tick ? 8'h00 : st_ff.cnt + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;
endmodule

// [src/ascq_fifo.sv]
// circular result buffer with registered read data
// assumes push and pop come from logic on pclk
`timescale 1ns/1ps
module ascq_fifo #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] rd_data,
	output logic [3:0] head,
	output logic [3:0] tail,
	output logic full,
	output logic empty
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [3:0] head;
		logic [3:0] tail;
		logic [3:0] count;
		logic [WIDTH-1:0] rd;
	} ascq_fifo_st_t;

	ascq_fifo_st_t st_ff;
	ascq_fifo_st_t nxt_st;

	function automatic logic [3:0] ascq_wrap(input logic [3:0] p);
		ascq_wrap = (p == 4'(DEPTH - 1)) ? 4'h0 : p + 4'h1;
	endfunction

	assign full = (st_ff.count == 4'(DEPTH));
	assign empty = (st_ff.count == 4'h0);

	always_comb begin
		nxt_st = st_ff;
		// a push into a full buffer is dropped; the caller flags overflow
		if (push && !full) begin
			nxt_st.mem[st_ff.head] = push_data;
			nxt_st.head = ascq_wrap(st_ff.head);
		end
		if (pop && !empty) begin
			nxt_st.rd = st_ff.mem[st_ff.tail];
			nxt_st.tail = ascq_wrap(st_ff.tail);
		end
		nxt_st.count = st_ff.count + 4'((push && !full) ? 1 : 0) - 4'((pop && !empty) ? 1 : 0);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rd_data = st_ff.rd;
	assign head = st_ff.head;
	assign tail = st_ff.tail;
endmodule

// [src/ascq_top.sv]
// sample sequencer control: APB registers, triggers, arbitration, sequencing, averaging, result buffers
// assumes an APB master on pclk and a converter core on pclk that answers conv_start with conv_done
//
// Function
// - four sequencers: 8, 4, 4, 1 steps and buffers
// - buffer word is 32 bits, result in low 10
// - each step: input nibble and control nibble
// - control nibble: temp, interrupt, end, differential bits
// - sequencer starts only while its enable bit set; a running sequence continues if it is cleared
// - same input allowed in several steps
// - per-step interrupt bits honoured in any combination
// - sequence stops after the end-marked step
// - buffer read at one address pops oldest entry
// - status shows head, tail, full and empty
// - overflow and underflow recorded per sequencer separately
// - converter logic runs near 16.667 MHz, automatic divider
// - raw status readable; mask gates interrupt output
// - status-clear shows masked raw; write one clears
// - pending triggers served by priority, 0 highest
// - per-sequencer trigger select, software and always included
// - initiate register bit starts that sequencer
// - averaging of up to 64 conversions per entry
// - averaging off at reset, one shared setting
// - single-ended code passes 0x000 to 0x3FF
// - differential pair n uses inputs 2n and 2n+1
// - differential code centred at 0x1FF passes through
// - reset priorities: first highest, fourth lowest
`timescale 1ns/1ps
`include "ascq_defines.svh"
module ascq_top
	import ascq_pkg::*;
#(
	parameter int DIV = `ASCQ_CONV_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] ext_trig,
	output logic conv_start,
	output logic [1:0] conv_pos_sel,
	output logic [1:0] conv_neg_sel,
	output logic conv_diff,
	output logic conv_temp,
	input wire logic conv_done,
	input wire logic [9:0] conv_result,
	output logic [3:0] seq_irq
);
	// ==========================================================
	// decode helpers
	function automatic logic [3:0] ascq_steps(input logic [1:0] s);
		unique case (s)
			2'h0: ascq_steps = 4'h8;
			2'h3: ascq_steps = 4'h1;
			default: ascq_steps = 4'h4;
		endcase
	endfunction

	function automatic logic [31:0] ascq_step_mask(input logic [1:0] s);
		unique case (s)
			2'h0: ascq_step_mask = 32'hFFFFFFFF;
			2'h3: ascq_step_mask = 32'h0000000F;
			default: ascq_step_mask = 32'h0000FFFF;
		endcase
	endfunction

	function automatic logic ascq_in_seq(input logic [11:0] a);
		ascq_in_seq = (a[11:5] >= `ASCQ_SEQ_BLK_FIRST) && (a[11:5] <= `ASCQ_SEQ_BLK_LAST) && !a[4];
	endfunction

	// ==========================================================
	// state, buffers and divider
	ascq_st_t st_ff;
	ascq_st_t nxt;
	logic conv_tick;
	logic [3:0] fifo_push;
	logic [3:0] fifo_pop;
	logic [3:0] fifo_full;
	logic [3:0] fifo_empty;
	logic [3:0][3:0] fifo_head;
	logic [3:0][3:0] fifo_tail;
	logic [3:0][9:0] fifo_data;
	logic grant_ok;
	logic [1:0] grant_idx;
	logic prio_ok;
	logic acc1;
	logic acc_done;
	logic hit_seq;
	logic [1:0] a_seq;
	logic [3:0] cur_sel;
	logic [3:0] cur_ctl;
	logic [2:0] avg_eff;
	logic [15:0] sum;
	logic [3:0] trig_rise;
	logic [3:0] code;

	ascq_clkdiv #(.DIV(DIV)) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick(conv_tick)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_fifo
			ascq_fifo #(.DEPTH((gi == 0) ? 8 : ((gi == 3) ? 1 : 4)), .WIDTH(10)) u_fifo (
				.pclk(pclk),
				.presetn(presetn),
				.push(fifo_push[gi]),
				.push_data(st_ff.result),
				.pop(fifo_pop[gi]),
				.rd_data(fifo_data[gi]),
				.head(fifo_head[gi]),
				.tail(fifo_tail[gi]),
				.full(fifo_full[gi]),
				.empty(fifo_empty[gi])
			);
		end
	endgenerate

	assign acc1 = psel && penable && !st_ff.apb_wait;
	assign acc_done = psel && penable && st_ff.apb_wait;
	assign hit_seq = ascq_in_seq(paddr);
	assign a_seq = 2'(paddr[11:5] - `ASCQ_SEQ_BLK_FIRST);
	assign cur_sel = st_ff.insel[st_ff.seq][{st_ff.step, 2'b00} +: 4];
	assign cur_ctl = st_ff.ctl[st_ff.seq][{st_ff.step, 2'b00} +: 4];
	assign avg_eff = (st_ff.avg > `ASCQ_AVG_MAX_LOG) ? `ASCQ_AVG_MAX_LOG : st_ff.avg;
	assign sum = st_ff.acc + {6'h00, conv_result};

	// ==========================================================
	// arbitration among pending triggers
	always_comb begin
		grant_ok = 1'b0;
		grant_idx = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (st_ff.pend[i] && st_ff.active[i] &&
				(!grant_ok || st_ff.pri[4*i +: 2] < st_ff.pri[4*grant_idx +: 2])) begin
				grant_ok = 1'b1;
				grant_idx = 2'(i);
			end
		end
		prio_ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (st_ff.pend[i] && st_ff.active[i] && st_ff.pri[4*i +: 2] < st_ff.pri[4*grant_idx +: 2]) begin
				prio_ok = 1'b0;
			end
		end
	end

	// ==========================================================
	// next-state logic
	always_comb begin
		nxt = st_ff;
		nxt.conv_start = 1'b0;
		fifo_push = 4'h0;
		fifo_pop = 4'h0;
		trig_rise = 4'h0;
		code = 4'h0;

		// trigger pins: three flops, a change counts when the last two agree
		nxt.sync1 = ext_trig;
		nxt.sync2 = st_ff.sync1;
		nxt.sync3 = st_ff.sync2;
		for (int i = 0; i < 4; i++) begin
			if (st_ff.sync2[i] == st_ff.sync3[i]) begin
				nxt.trig_lvl[i] = st_ff.sync3[i];
				trig_rise[i] = st_ff.sync3[i] && !st_ff.trig_lvl[i];
			end
		end

		// apb: first access cycle captures read data, second completes
		if (acc1) begin
			nxt.apb_wait = 1'b1;
			nxt.fifo_rd = 1'b0;
			nxt.err = 1'b0;
			nxt.rdata = 32'h00000000;
			if (hit_seq) begin
				unique case (paddr[3:2])
					`ASCQ_SUB_INSEL: nxt.rdata = st_ff.insel[a_seq];
					`ASCQ_SUB_CTL: nxt.rdata = st_ff.ctl[a_seq];
					`ASCQ_SUB_FIFO: begin
						nxt.fifo_rd = !pwrite;
						fifo_pop[a_seq] = !pwrite;
						if (!pwrite && fifo_empty[a_seq]) begin
							nxt.unf[a_seq] = 1'b1;
						end
					end
					`ASCQ_SUB_STAT: begin
						nxt.rdata[`ASCQ_STAT_TAIL +: 4] = fifo_tail[a_seq];
						nxt.rdata[`ASCQ_STAT_HEAD +: 4] = fifo_head[a_seq];
						nxt.rdata[`ASCQ_STAT_EMPTY] = fifo_empty[a_seq];
						nxt.rdata[`ASCQ_STAT_FULL] = fifo_full[a_seq];
					end
				endcase
			end else begin
				unique case (paddr)
					`ASCQ_OFF_ACTIVE: nxt.rdata[3:0] = st_ff.active;
					`ASCQ_OFF_RAW: nxt.rdata[3:0] = st_ff.raw;
					`ASCQ_OFF_MASK: nxt.rdata[3:0] = st_ff.mask;
					`ASCQ_OFF_ISC: nxt.rdata[3:0] = st_ff.raw & st_ff.mask;
					`ASCQ_OFF_OVF: nxt.rdata[3:0] = st_ff.ovf;
					`ASCQ_OFF_EMUX: nxt.rdata[15:0] = st_ff.emux;
					`ASCQ_OFF_UNF: nxt.rdata[3:0] = st_ff.unf;
					`ASCQ_OFF_PRI: nxt.rdata[15:0] = st_ff.pri;
					`ASCQ_OFF_INIT: nxt.rdata = 32'h00000000;
					`ASCQ_OFF_AVG: nxt.rdata[2:0] = st_ff.avg;
					default: nxt.err = 1'b1;
				endcase
			end
		end

		// writes land at the completing edge; hardware sets below win over clears
		if (acc_done) begin
			nxt.apb_wait = 1'b0;
			if (pwrite && hit_seq) begin
				unique case (paddr[3:2])
					`ASCQ_SUB_INSEL: nxt.insel[a_seq] = pwdata & ascq_step_mask(a_seq);
					`ASCQ_SUB_CTL: nxt.ctl[a_seq] = pwdata & ascq_step_mask(a_seq);
					default: ;
				endcase
			end else if (pwrite) begin
				unique case (paddr)
					`ASCQ_OFF_ACTIVE: nxt.active = pwdata[3:0];
					`ASCQ_OFF_MASK: nxt.mask = pwdata[3:0];
					`ASCQ_OFF_ISC: nxt.raw = st_ff.raw & ~pwdata[3:0];
					`ASCQ_OFF_OVF: nxt.ovf = st_ff.ovf & ~pwdata[3:0];
					`ASCQ_OFF_UNF: nxt.unf = nxt.unf & ~pwdata[3:0];
					`ASCQ_OFF_EMUX: nxt.emux = pwdata[15:0];
					`ASCQ_OFF_PRI: nxt.pri = pwdata[15:0] & `ASCQ_PRI_MASK;
					`ASCQ_OFF_INIT: nxt.pend = st_ff.pend | (pwdata[3:0] & st_ff.active);
					`ASCQ_OFF_AVG: nxt.avg = pwdata[2:0];
					default: ;
				endcase
			end
		end

		// sequencer engine
		unique case (st_ff.state)
			SEQ_IDLE: begin
				if (grant_ok) begin
					nxt.seq = grant_idx;
					nxt.step = 3'h0;
					nxt.pend[grant_idx] = 1'b0;
					nxt.acc = 16'h0000;
					nxt.avg_cnt = 7'h00;
					nxt.state = SEQ_START;
				end
			end
			SEQ_START: begin
				if (conv_tick) begin
					nxt.conv_start = 1'b1;
					nxt.diff = cur_ctl[`ASCQ_CTL_DIFF];
					nxt.temp = cur_ctl[`ASCQ_CTL_TEMP];
					nxt.pos_sel = cur_ctl[`ASCQ_CTL_DIFF] ? {cur_sel[0], 1'b0} : cur_sel[1:0];
					nxt.neg_sel = {cur_sel[0], 1'b1};
					nxt.state = SEQ_WAIT;
				end
			end
			SEQ_WAIT: begin
				if (conv_done) begin
					nxt.acc = sum;
					nxt.avg_cnt = st_ff.avg_cnt + 7'h01;
					if ((st_ff.avg_cnt + 7'h01) == (7'h01 << avg_eff)) begin
						nxt.result = 10'(sum >> avg_eff);
						nxt.state = SEQ_STORE;
					end else begin
						nxt.state = SEQ_START;
					end
				end
			end
			SEQ_STORE: begin
				fifo_push[st_ff.seq] = 1'b1;
				if (fifo_full[st_ff.seq]) begin
					nxt.ovf[st_ff.seq] = 1'b1;
				end
				if (cur_ctl[`ASCQ_CTL_IRQ]) begin
					nxt.raw[st_ff.seq] = 1'b1;
				end
				nxt.acc = 16'h0000;
				nxt.avg_cnt = 7'h00;
				if (cur_ctl[`ASCQ_CTL_END] || ({1'b0, st_ff.step} == ascq_steps(st_ff.seq) - 4'h1)) begin
					nxt.state = SEQ_IDLE;
				end else begin
					nxt.step = st_ff.step + 3'h1;
					nxt.state = SEQ_START;
				end
			end
		endcase

		// trigger capture; a disabled sequencer drops its pending request
		for (int i = 0; i < 4; i++) begin
			code = st_ff.emux[4*i +: 4];
			if ((code == `ASCQ_TRIG_ALWAYS) || ((code != `ASCQ_TRIG_SW) && trig_rise[code[1:0]])) begin
				nxt.pend[i] = 1'b1;
			end
			if (!nxt.active[i]) begin
				nxt.pend[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.pri <= `ASCQ_RST_PRI;
			st_ff.ctl[3] <= `ASCQ_RST_CTL3;
		end else begin
			st_ff <= nxt;
		end
	end

	// ==========================================================
	// outputs
	assign pready = acc_done;
	assign pslverr = acc_done && st_ff.err;
	assign prdata = st_ff.fifo_rd ? {22'h000000, fifo_data[a_seq]} : st_ff.rdata;
	assign seq_irq = st_ff.raw & st_ff.mask;
	assign conv_start = st_ff.conv_start;
	assign conv_pos_sel = st_ff.pos_sel;
	assign conv_neg_sel = st_ff.neg_sel;
	assign conv_diff = st_ff.diff;
	assign conv_temp = st_ff.temp;

	// ==========================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_step_bound;
		st_ff.state != SEQ_IDLE |-> {1'b0, st_ff.step} < ascq_steps(st_ff.seq);
	endproperty
	a_step_bound: assert property (p_step_bound) else $error("step beyond sequencer length");

	property p_result_width;
		pready && st_ff.fifo_rd |-> prdata[31:10] == 22'h000000;
	endproperty
	a_result_width: assert property (p_result_width) else $error("result word upper bits set");

	property p_run_enabled;
		st_ff.state == SEQ_IDLE && grant_ok |-> st_ff.active[grant_idx] ##1 st_ff.state == SEQ_START;
	endproperty
	a_run_enabled: assert property (p_run_enabled) else $error("disabled sequencer started");

	property p_irq_step;
		st_ff.state == SEQ_STORE && cur_ctl[`ASCQ_CTL_IRQ] |=> st_ff.raw[$past(st_ff.seq)];
	endproperty
	a_irq_step: assert property (p_irq_step) else $error("step interrupt not raised");

	property p_end_stop;
		st_ff.state == SEQ_STORE && cur_ctl[`ASCQ_CTL_END] |=> st_ff.state == SEQ_IDLE;
	endproperty
	a_end_stop: assert property (p_end_stop) else $error("sequence ran past end step");

	property p_pop;
		fifo_pop[0] && !fifo_empty[0] |=> fifo_tail[0] != $past(fifo_tail[0]);
	endproperty
	a_pop: assert property (p_pop) else $error("read did not pop");

	property p_ovf;
		st_ff.state == SEQ_STORE && fifo_full[st_ff.seq] |=> st_ff.ovf[$past(st_ff.seq)];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not recorded");

	property p_tick_gap;
		conv_tick |=> !conv_tick ##1 !conv_tick ##1 conv_tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("converter enable spacing wrong");

	property p_start_tick;
		conv_start |-> $past(conv_tick) ##1 !conv_start;
	endproperty
	a_start_tick: assert property (p_start_tick) else $error("start off the converter enable");

	property p_prio;
		st_ff.state == SEQ_IDLE && grant_ok |-> prio_ok;
	endproperty
	a_prio: assert property (p_prio) else $error("lower priority served first");

	property p_avg_off;
		st_ff.state == SEQ_WAIT && conv_done && st_ff.avg == 3'h0 |=>
			st_ff.state == SEQ_STORE && st_ff.result == $past(conv_result);
	endproperty
	a_avg_off: assert property (p_avg_off) else $error("unaveraged result altered");

	c_fifo_full: cover property (fifo_full[0]);
	c_irq: cover property (seq_irq != 4'h0);
	c_avg: cover property (st_ff.state == SEQ_STORE && st_ff.avg != 3'h0);
	c_unf: cover property (st_ff.unf != 4'h0);
endmodule

// [verification/ascq_conv_model.sv]
// converter core model: answers each conv_start with one conv_done and a code
// assumes a one-cycle conv_start pulse on pclk and selects held from it
`timescale 1ns/1ps
module ascq_conv_model #(
	parameter int SLOW = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic conv_start,
	input wire logic [1:0] conv_pos_sel,
	input wire logic [1:0] conv_neg_sel,
	input wire logic conv_diff,
	input wire logic conv_temp,
	output logic conv_done,
	output logic [9:0] conv_result,
	output int n_done
);
	int cnt;
	logic [9:0] code;
	logic [9:0] hold;
	// ==========================================================
	// code per selection
	always_comb begin
		if (conv_temp) begin
			code = 10'h2AA;
		end else if (!conv_diff) begin
			code = {conv_pos_sel, 8'h5A};
		end else if (conv_pos_sel[0] || conv_neg_sel != (conv_pos_sel | 2'h1)) begin
			code = 10'h000;
		end else begin
			code = 10'h1FF + {2'h0, conv_pos_sel, 6'h00};
		end
	end
	// ==========================================================
	// answer after a short or long delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			hold <= 10'h000;
			conv_done <= 1'b0;
			conv_result <= 10'h000;
			n_done <= 0;
		end else begin
			conv_done <= 1'b0;
			// result lines show garbage outside the answer cycle
			conv_result <= ~conv_result;
			if (conv_start) begin
				cnt <= slow ? SLOW : 1;
				hold <= code;
			end else if (cnt == 1) begin
				cnt <= 0;
				conv_done <= 1'b1;
				conv_result <= hold;
				n_done <= n_done + 1;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// [verification/ascq_top_tb.sv]
// testbench of the sequencer control block: APB tasks and directed tests
// assumes the converter model beside the design
`timescale 1ns/1ps
`include "ascq_defines.svh"
module ascq_top_tb
	import ascq_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] ext_trig = 4'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, perr, conv_start, conv_diff, conv_temp, conv_done;
	logic [1:0] conv_pos_sel, conv_neg_sel;
	logic [9:0] conv_result;
	logic [3:0] seq_irq;
	logic [31:0] ev[5] = '{32'h15A, 32'h15A, 32'h27F, 32'h2AA, 32'h35A};
	logic [1:0] sq[$];
	int n_done, base;
	int n_fail = 0;
	int compares = 0;

	always #10 pclk = ~pclk;
	always @(negedge pclk) if (conv_start === 1'b1) sq.push_back(conv_pos_sel);

	ascq_top u_ascq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_trig(ext_trig), .conv_start(conv_start), .conv_pos_sel(conv_pos_sel),
		.conv_neg_sel(conv_neg_sel), .conv_diff(conv_diff), .conv_temp(conv_temp),
		.conv_done(conv_done), .conv_result(conv_result), .seq_irq(seq_irq));
	ascq_conv_model u_ascq_conv_model (.pclk(pclk), .presetn(presetn), .slow(slow),
		.conv_start(conv_start), .conv_pos_sel(conv_pos_sel), .conv_neg_sel(conv_neg_sel),
		.conv_diff(conv_diff), .conv_temp(conv_temp), .conv_done(conv_done),
		.conv_result(conv_result), .n_done(n_done));

	// ==========================================================
	// tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request held until pready is seen high at a rising edge; data taken at that edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: bus transfer never completed", $time);
			give_verdict;
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task rdb(input logic [11:0] a, input int b);
		apb(1'b0, a, 32'h0);
		chk({31'h0, rd[b]}, 32'h1);
	endtask

	task wait_done(input int k);
		int n;
		n = 0;
		while (n_done < k && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		if (n_done < k) begin
			n_fail++;
			$display("unexpected at %0t: conversions never completed", $time);
			give_verdict;
		end
		// the push lands two edges after the last answer
		repeat (3) @(posedge pclk);
	endtask

	task give_verdict;
		$display("comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// tests need a few hundred cycles
	initial begin
		#400000;
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict;
	end

	// ==========================================================
	// tests
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`ASCQ_OFF_PRI, 32'h3210);
		rdc(12'h0A4, 32'h2);
		rdc(12'h04C, 32'h100);
		rdc(`ASCQ_OFF_AVG, 32'h0);
		rdc(12'h0FC, 32'h0);
		chk({31'h0, perr}, 32'h1);
		$display("test reset done");

		apb(1'b1, 12'h0A0, 32'h2);
		apb(1'b1, `ASCQ_OFF_INIT, 32'h8);
		base = n_done;
		apb(1'b1, `ASCQ_OFF_ACTIVE, 32'h8);
		apb(1'b1, `ASCQ_OFF_INIT, 32'h8);
		wait_done(base + 1);
		rdc(12'h0A8, 32'h25A);
		rdb(12'h0AC, 8);
		rdc(`ASCQ_OFF_OVF, 32'h0);
		apb(1'b1, `ASCQ_OFF_ACTIVE, 32'h0);
		$display("test enable done");

		apb(1'b1, 12'h040, 32'h22230111);
		apb(1'b1, 12'h044, 32'h00268104);
		apb(1'b1, `ASCQ_OFF_ACTIVE, 32'h1);
		slow <= 1'b1;
		base = n_done;
		apb(1'b1, `ASCQ_OFF_INIT, 32'h1);
		wait_done(base + 5);
		chk({28'h0, seq_irq}, 32'h0);
		rdc(`ASCQ_OFF_RAW, 32'h1);
		rdc(`ASCQ_OFF_ISC, 32'h0);
		apb(1'b1, `ASCQ_OFF_MASK, 32'h1);
		rdc(`ASCQ_OFF_ISC, 32'h1);
		chk({28'h0, seq_irq}, 32'h1);
		apb(1'b1, `ASCQ_OFF_ISC, 32'h1);
		rdc(`ASCQ_OFF_RAW, 32'h0);
		for (int i = 0; i < 5; i++) rdc(12'h048, ev[i]);
		rdb(12'h04C, 8);
		chk(n_done - base, 32'd5);
		apb(1'b0, 12'h048, 32'h0);
		rdc(`ASCQ_OFF_UNF, 32'h1);
		apb(1'b1, `ASCQ_OFF_UNF, 32'h1);
		rdc(`ASCQ_OFF_UNF, 32'h0);
		$display("test sequence done");

		apb(1'b1, 12'h060, 32'h1);
		apb(1'b1, 12'h064, 32'h2);
		apb(1'b1, 12'h080, 32'h3);
		apb(1'b1, 12'h084, 32'h2);
		apb(1'b1, `ASCQ_OFF_PRI, 32'h3012);
		apb(1'b1, `ASCQ_OFF_ACTIVE, 32'h7);
		sq.delete();
		base = n_done;
		apb(1'b1, `ASCQ_OFF_INIT, 32'h6);
		wait_done(base + 2);
		chk({30'h0, sq[0]}, 32'h3);
		chk({30'h0, sq[1]}, 32'h1);
		apb(1'b1, `ASCQ_OFF_EMUX, 32'h20);
		base = n_done;
		ext_trig <= 4'h4;
		wait_done(base + 1);
		ext_trig <= 4'h0;
		rdc(12'h068, 32'h15A);
		rdc(12'h068, 32'h15A);
		rdc(12'h088, 32'h35A);
		$display("test priority done");

		apb(1'b1, 12'h040, 32'h3);
		apb(1'b1, 12'h044, 32'h2);
		apb(1'b1, `ASCQ_OFF_AVG, 32'h2);
		base = n_done;
		apb(1'b1, `ASCQ_OFF_INIT, 32'h1);
		wait_done(base + 4);
		rdc(12'h048, 32'h35A);
		rdb(12'h04C, 8);
		apb(1'b1, `ASCQ_OFF_AVG, 32'h0);
		$display("test averaging done");

		slow <= 1'b0;
		apb(1'b1, `ASCQ_OFF_EMUX, 32'hF020);
		base = n_done;
		apb(1'b1, `ASCQ_OFF_ACTIVE, 32'h8);
		wait_done(base + 3);
		rdc(`ASCQ_OFF_OVF, 32'h8);
		rdb(12'h0AC, 12);
		apb(1'b1, `ASCQ_OFF_ACTIVE, 32'h0);
		$display("test continuous done");
		give_verdict;
	end
endmodule
